/* File: design/fbp_regs.svh */
// Register offsets, field positions and reset values of the flash block protection logic
`ifndef FBP_REGS_SVH
`define FBP_REGS_SVH

// ==========================================================
// Register byte offsets
`define FBP_A2CTL_OFS 16'hfe08
`define FBP_A1CTL_OFS 16'hfe10
`define FBP_A1BPR_OFS 16'hfe14
`define FBP_A2BPR_OFS 16'hfe18
`define FBP_TGT_OFS 16'hfe1c
`define FBP_STAT_OFS 16'hfe20

// ==========================================================
// Control register fields
`define FBP_CTL_PGM 0
`define FBP_CTL_ERASE 1
`define FBP_CTL_MASS 2
`define FBP_CTL_HIGH_VOLTAGE_ENABLE 3

// ==========================================================
// Status register fields
`define FBP_ST_PROT 0
`define FBP_ST_STBY 1
`define FBP_ST_REFUSED 2
`define FBP_ST_BPRRD 3

// ==========================================================
// Values
`define FBP_BPR_ERASED 8'hff
`define FBP_BPR_ALL 8'h00
`define FBP_CTL_RESET 4'h0
`define FBP_TGT_RESET 16'h0000
`define FBP_VEC_PAGE 9'h1ff
`define FBP_A1_HI 1'b1
`define FBP_A2_HI 1'b0

`endif

/* File: design/fbp_pkg.sv */
// Types shared by the flash block protection logic
`default_nettype none
`include "fbp_regs.svh"

package fbp_pkg;

	typedef struct packed {
		logic high_voltage_enable;
		logic mass;
		logic erase;
		logic write_select_bit;
	} fbp_ctl_s;

	typedef struct packed {
		logic ack;
		logic [15:0] rdat;
		logic [3:0] ctl1;
		logic [3:0] ctl2;
		logic [7:0] bpr1;
		logic [7:0] bpr2;
		logic [15:0] tgt;
		logic refused;
		logic bpr_rd;
		logic wait_s1;
		logic wait_s2;
		logic stop_s1;
		logic stop_s2;
	} fbp_state_s;

endpackage

`default_nettype wire

/* File: design/fbp_range.sv */
// Protected-range decode for one flash array
`timescale 1ns/100ps
`default_nettype none
`include "fbp_regs.svh"

module fbp_range
	import fbp_pkg::*;
(
	// Protect value and array select
	input wire logic [7:0] bpr,
	input wire logic array_hi,
	// Address under test
	input wire logic [15:0] addr,
	// Result
	output logic prot
);

	logic [15:0] start;
	logic in_array;

	// Page-aligned start; missing flash inside the range does not move it
	assign start = {array_hi, bpr, 7'h00};
	assign in_array = (addr[15] == array_hi);

	always_comb begin
		if (bpr == `FBP_BPR_ERASED) begin
			prot = 1'b0;
		end else if (bpr == `FBP_BPR_ALL) begin
			prot = 1'b1;
		end else begin
			prot = in_array && (addr >= start);
		end
	end

endmodule // fbp_range

`default_nettype wire

/* File: design/fbp_top.sv */
// Flash block protection and program/erase control with Wishbone register access
// Summary of operation
// - Protection runs from decoded start to top
// - Each value decrement adds one 128-byte page
// - Value fe protects ff00 through ffff in array 1, 7f00 through 7fff in array 2
// - Protected target refuses high-voltage enable set
// - All zeros protects the whole array
// - All ones leaves everything unprotected
// - Any value but ff activates protection
// - Boundary ignores holes in physical flash
// - Unprotected vector page erase clears protect registers
// - Wait mode suspends program/erase, enters standby
// - Stop mode suspends program/erase, enters standby
// - Standby drives all flash controls inactive
// - Read mode unaffected by wait or stop
`timescale 1ns/100ps
`default_nettype none
`include "fbp_regs.svh"

module fbp_top
	import fbp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Low-power mode requests from the system
	input wire logic wait_mode,
	input wire logic stop_mode,
	// Flash array controls
	output fbp_ctl_s array1_ctl,
	output fbp_ctl_s array2_ctl,
	output logic flash_standby
);

	// ==========================================================
	// State
	localparam fbp_state_s FBP_RESET = '{
		ack: 1'b0,
		rdat: 16'h0000,
		ctl1: `FBP_CTL_RESET,
		ctl2: `FBP_CTL_RESET,
		bpr1: `FBP_BPR_ERASED,
		bpr2: `FBP_BPR_ERASED,
		tgt: `FBP_TGT_RESET,
		refused: 1'b0,
		bpr_rd: 1'b0,
		wait_s1: 1'b0,
		wait_s2: 1'b0,
		stop_s1: 1'b0,
		stop_s2: 1'b0
	};

	fbp_state_s state_r;
	fbp_state_s state_nxt;

	logic prot1;
	logic prot2;
	logic low_power;
	logic req;
	logic wr_lo;
	logic wr_hi;
	logic [15:0] rd_mux;
	logic [3:0] new1;
	logic [3:0] new2;
	logic ref1;
	logic ref2;

	// ==========================================================
	// Control register write
	// HIGH_VOLTAGE_ENABLE only sticks when a mode is selected, the target is unprotected
	// and the block is not in low power.
	function automatic logic [3:0] fbp_ctl_wr(input logic [7:0] d, input logic prot, input logic lp);
		logic [3:0] v;
		v = d[3:0];
		if (prot || lp || !(v[`FBP_CTL_PGM] || v[`FBP_CTL_ERASE])) begin
			v[`FBP_CTL_HIGH_VOLTAGE_ENABLE] = 1'b0;
		end
		return v;
	endfunction

	function automatic logic fbp_refuse(input logic [7:0] d, input logic prot);
		return d[`FBP_CTL_HIGH_VOLTAGE_ENABLE] && prot;
	endfunction

	// ==========================================================
	// Protection decode against the target address
	fbp_range u_range1 (
		.bpr(state_r.bpr1),
		.array_hi(`FBP_A1_HI),
		.addr(state_r.tgt),
		.prot(prot1)
	);

	fbp_range u_range2 (
		.bpr(state_r.bpr2),
		.array_hi(`FBP_A2_HI),
		.addr(state_r.tgt),
		.prot(prot2)
	);

	// ==========================================================
	// Bus decode
	assign low_power = state_r.wait_s2 || state_r.stop_s2;
	assign req = wb_cyc_i && wb_stb_i && !state_r.ack;
	assign wr_lo = req && wb_we_i && wb_sel_i[0];
	assign wr_hi = req && wb_we_i && wb_sel_i[1];

	always_comb begin
		rd_mux = 16'h0000;
		unique case (wb_adr_i)
			`FBP_A1CTL_OFS: rd_mux = {12'h000, state_r.ctl1};
			`FBP_A2CTL_OFS: rd_mux = {12'h000, state_r.ctl2};
			`FBP_A1BPR_OFS: rd_mux = {8'h00, state_r.bpr1};
			`FBP_A2BPR_OFS: rd_mux = {8'h00, state_r.bpr2};
			`FBP_TGT_OFS: rd_mux = state_r.tgt;
			`FBP_STAT_OFS: rd_mux = {12'h000, state_r.bpr_rd, state_r.refused, low_power,
				state_r.tgt[15] ? prot1 : prot2};
			default: rd_mux = 16'h0000;
		endcase
	end

	assign new1 = fbp_ctl_wr(wb_dat_i[7:0], prot1, low_power);
	assign new2 = fbp_ctl_wr(wb_dat_i[7:0], prot2, low_power);
	assign ref1 = fbp_refuse(wb_dat_i[7:0], prot1);
	assign ref2 = fbp_refuse(wb_dat_i[7:0], prot2);

	// ==========================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		state_nxt.ack = req;
		state_nxt.wait_s1 = wait_mode;
		state_nxt.wait_s2 = state_r.wait_s1;
		state_nxt.stop_s1 = stop_mode;
		state_nxt.stop_s2 = state_r.stop_s1;

		if (req && !wb_we_i) begin
			state_nxt.rdat = rd_mux;
			// Note the protect read that must come between select and enable
			if ((wb_adr_i == `FBP_A1BPR_OFS || wb_adr_i == `FBP_A2BPR_OFS) &&
				(state_r.ctl1[1:0] != 2'b00 || state_r.ctl2[1:0] != 2'b00)) begin
				state_nxt.bpr_rd = 1'b1;
			end
		end

		if (wr_lo) begin
			unique case (wb_adr_i)
				`FBP_A1CTL_OFS: begin
					state_nxt.ctl1 = new1;
					// Vectors share the page with both protect values
					if (new1[`FBP_CTL_HIGH_VOLTAGE_ENABLE] && !state_r.ctl1[`FBP_CTL_HIGH_VOLTAGE_ENABLE] && new1[`FBP_CTL_ERASE] &&
						(new1[`FBP_CTL_MASS] || state_r.tgt[15:7] == `FBP_VEC_PAGE)) begin
						state_nxt.bpr1 = `FBP_BPR_ERASED;
						state_nxt.bpr2 = `FBP_BPR_ERASED;
					end
					if (new1[1:0] == 2'b00) begin
						state_nxt.bpr_rd = 1'b0;
					end
				end
				`FBP_A2CTL_OFS: begin
					state_nxt.ctl2 = new2;
					if (new2[1:0] == 2'b00) begin
						state_nxt.bpr_rd = 1'b0;
					end
				end
				// Nonvolatile cells only program ones to zeros
				`FBP_A1BPR_OFS: state_nxt.bpr1 = state_r.bpr1 & wb_dat_i[7:0];
				`FBP_A2BPR_OFS: state_nxt.bpr2 = state_r.bpr2 & wb_dat_i[7:0];
				`FBP_TGT_OFS: state_nxt.tgt[7:0] = wb_dat_i[7:0];
				`FBP_STAT_OFS: begin
					if (wb_dat_i[`FBP_ST_REFUSED]) begin
						state_nxt.refused = 1'b0;
					end
				end
				default: state_nxt.tgt = state_nxt.tgt;
			endcase
		end

		if (wr_hi && wb_adr_i == `FBP_TGT_OFS) begin
			state_nxt.tgt[15:8] = wb_dat_i[15:8];
		end

		// Set wins over a clear in the same cycle
		if (wr_lo && ((wb_adr_i == `FBP_A1CTL_OFS && ref1) || (wb_adr_i == `FBP_A2CTL_OFS && ref2))) begin
			state_nxt.refused = 1'b1;
		end

		// Low power aborts any operation and also clears a mode that is selected but not yet enabled
		if (low_power) begin
			state_nxt.ctl1 = `FBP_CTL_RESET;
			state_nxt.ctl2 = `FBP_CTL_RESET;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= FBP_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign wb_ack_o = state_r.ack;
	assign wb_dat_o = {16'h0000, state_r.rdat};
	assign flash_standby = low_power;
	// Gated at once so the pump drops in the same cycle standby starts
	assign array1_ctl = low_power ? fbp_ctl_s'(`FBP_CTL_RESET) : fbp_ctl_s'(state_r.ctl1);
	assign array2_ctl = low_power ? fbp_ctl_s'(`FBP_CTL_RESET) : fbp_ctl_s'(state_r.ctl2);

endmodule // fbp_top

`default_nettype wire

/* File: sim/fbp_chk.sv */
// Port checker for flash block protection
`timescale 1ns/100ps
`default_nettype none
module fbp_chk
	import fbp_pkg::*;
(
	// Clock and bus
	input wire logic clk,
	input wire logic nrst,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	// Modes and controls
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire fbp_ctl_s array1_ctl,
	input wire fbp_ctl_s array2_ctl,
	input wire logic flash_standby
);
	// ====
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_stby_ctl_off: assert property (flash_standby |-> array1_ctl == 0 && array2_ctl == 0)
		else $error("flash controls active in standby");
	a_wait_stby: assert property (wait_mode [*3] |-> flash_standby)
		else $error("wait did not reach standby");
	a_stop_stby: assert property (stop_mode [*3] |-> flash_standby)
		else $error("stop did not reach standby");
	a_stby_leave: assert property ((!wait_mode && !stop_mode) [*3] |-> !flash_standby)
		else $error("standby without low power");
	a_suspend_kept: assert property ($fell(flash_standby) |-> array1_ctl == 0 && array2_ctl == 0)
		else $error("operation resumed after standby");
	a_hven1_mode: assert property ($rose(array1_ctl.high_voltage_enable) |-> array1_ctl.write_select_bit || array1_ctl.erase)
		else $error("array1 enable without mode");
	a_hven2_mode: assert property ($rose(array2_ctl.high_voltage_enable) |-> array2_ctl.write_select_bit || array2_ctl.erase)
		else $error("array2 enable without mode");
	// Only a bus write or entry to standby may move the controls
	a_ctl_by_write: assert property ($changed({array1_ctl, array2_ctl}) |->
		$past(wb_stb_i && wb_we_i) || $rose(flash_standby))
		else $error("controls changed without write");
	c_stby: cover property ($rose(flash_standby));
	c_hven2: cover property ($rose(array2_ctl.high_voltage_enable));
	c_erase1: cover property ($rose(array1_ctl.erase));
endmodule // fbp_chk
bind fbp_top fbp_chk u_fbp_chk (.clk, .nrst, .wb_stb_i, .wb_we_i, .wait_mode, .stop_mode,
	.array1_ctl, .array2_ctl, .flash_standby);
`default_nettype wire

/* File: sim/fbp_cpu.sv */
// Software model sequencing program and erase over the bus
`timescale 1ns/100ps
`default_nettype none
module fbp_cpu (
	// Bus
	input wire logic clk,
	input wire logic ack,
	input wire logic [31:0] rdat,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [15:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat
);
	// ====
	// Transfers, entered just after a rising edge
	initial begin
		{cyc, stb, we, adr, sel, dat} = '0;
	end
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [31:0] q);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		dat <= {16'h0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	// Back-to-back steps keep well inside the pulse time target already a real location
	task automatic seq(input logic [15:0] c, input logic [15:0] b, input logic [3:0] m);
		logic [31:0] q;
		xfer(1, c, {12'h000, m}, q);
		xfer(0, b, 16'h0000, q);
		xfer(1, c, {12'h000, m | 4'h8}, q);
	endtask
endmodule // fbp_cpu
`default_nettype wire

/* File: sim/flash_block_protection_test.sv */
// Self-checking bench for flash block protection
`timescale 1ns/100ps
`default_nettype none
module flash_block_protection_test;
	import fbp_pkg::*;
	typedef struct packed {logic [15:0] o; logic [7:0] b; logic [15:0] t; logic e;} fbp_row_s;
	logic clk = 0, nrst = 0, wait_mode = 0, stop_mode = 0, cyc, stb, we, ack, stby;
	logic [15:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdat, q;
	fbp_ctl_s c1, c2;
	int fails = 0, total_checks = 0;
	// Protect writes can only clear bits, so each row keeps every bit that an earlier row for the same register cleared
	fbp_row_s rows [10] = '{'{16'hfe14, 8'hff, 16'hffff, 1'b0}, '{16'hfe14, 8'hfe, 16'hff00, 1'b1},
		'{16'hfe14, 8'hfe, 16'hfeff, 1'b0}, '{16'hfe14, 8'hfc, 16'hfe00, 1'b1}, '{16'hfe14, 8'hfc, 16'hfdff, 1'b0},
		'{16'hfe14, 8'h00, 16'h8000, 1'b1}, '{16'hfe18, 8'h81, 16'h4080, 1'b1}, '{16'hfe18, 8'h81, 16'h407f, 1'b0},
		'{16'hfe18, 8'h80, 16'h407f, 1'b1}, '{16'hfe18, 8'h80, 16'h3fff, 1'b0}};
	always #2.5 clk = ~clk;
	fbp_top u_fbp_top (.clk, .nrst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wait_mode, .stop_mode,
		.array1_ctl(c1), .array2_ctl(c2), .flash_standby(stby));
	fbp_cpu u_fbp_cpu (.clk, .ack, .rdat, .cyc, .stb, .we, .adr, .sel, .dat);
	// ====
	// Checking and bus helpers
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task rc(input logic [15:0] a, input logic [31:0] e);
		u_fbp_cpu.xfer(0, a, 16'h0000, q);
		chk(q, e);
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		u_fbp_cpu.xfer(1, a, d, q);
	endtask
	task rst();
		nrst <= 0;
		repeat (6) @(posedge clk);
		nrst <= 1;
	endtask
	task give_verdict();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ====
	// Sequence
	initial begin
		#50000;
		fails++;
		give_verdict();
	end
	initial begin
		rst();
		rc(16'hfe14, 32'hff);
		rc(16'hfe08, 32'h0);
		rc(16'hfe00, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].o, {8'h00, rows[i].b});
			wr(16'hfe1c, rows[i].t);
			rc(16'hfe20, {31'h0, rows[i].e});
		end
		// Vector page is protected here, so neither the erase nor the wipe may happen
		wr(16'hfe1c, 16'hff80);
		u_fbp_cpu.seq(16'hfe10, 16'hfe14, 4'h2);
		rc(16'hfe10, 32'h2);
		chk(c1, 32'h2);
		rc(16'hfe20, 32'hd);
		rc(16'hfe18, 32'h80);
		wr(16'hfe20, 16'h0004);
		rc(16'hfe20, 32'h9);
		wr(16'hfe10, 16'h0000);
		wr(16'hfe1c, 16'h0000);
		for (int m = 0; m < 2; m++) begin
			u_fbp_cpu.seq(16'hfe08, 16'hfe18, m ? 4'h1 : 4'h2);
			chk(c2.high_voltage_enable, 32'h1);
			wait_mode <= (m == 0); // Entered mid-operation on purpose
			stop_mode <= (m == 1);
			repeat (3) @(posedge clk);
			chk({stby, c2}, 5'h10);
			wait_mode <= 0;
			stop_mode <= 0;
			repeat (3) @(posedge clk);
			rc(16'hfe08, 32'h0);
		end
		rst();
		rc(16'hfe14, 32'hff);
		rc(16'hfe10, 32'h0);
		wr(16'hfe1c, 16'hff80);
		wr(16'hfe18, 16'h0000);
		u_fbp_cpu.seq(16'hfe10, 16'hfe14, 4'h2);
		chk(c1, 32'ha);
		rc(16'hfe18, 32'hff);
		// Mass erase wipes both protect values wherever the target points
		wr(16'hfe10, 16'h0000);
		wr(16'hfe1c, 16'h8000);
		wr(16'hfe18, 16'h0000);
		u_fbp_cpu.seq(16'hfe10, 16'hfe14, 4'h6);
		chk(c1, 32'he);
		rc(16'hfe18, 32'hff);
		give_verdict();
	end
endmodule // flash_block_protection_test
`default_nettype wire
